// >>> verilog/chg_sup_pkg.sv
// shared constants and carrier types for the charge supervision block
package chg_sup_pkg;
  // internal clock
  localparam int unsigned CLK_HZ = 50_000_000;
  // fault pulse width, 128 us
  localparam int unsigned PULSE_US = 128;
  localparam int unsigned PULSE_CYC = PULSE_US * (CLK_HZ / 1_000_000);
  // host watchdog, 30 s
  localparam int unsigned WDOG_S = 30;
  // fallback safety duration after watchdog expiry, 2 min
  localparam int unsigned DEFAULT_SAFETY_S = 120;
  // width of the safety duration select field and of the seconds counters
  localparam int unsigned DUR_W = 2;
  localparam int unsigned SEC_W = 16;
  localparam logic [DUR_W-1:0] DUR_SEL_RST = 2'h1;
  // safety durations in seconds for select codes 1 to 3; code 0 turns the timer off outside default mode
  localparam int unsigned SAFETY_S_SEL1 = 2700;
  localparam int unsigned SAFETY_S_SEL2 = 21600;
  localparam int unsigned SAFETY_S_SEL3 = 43200;
  // charge phase codes
  localparam logic [1:0] PHASE_READY = 2'h0;
  localparam logic [1:0] PHASE_CHARGING = 2'h1;
  localparam logic [1:0] PHASE_DONE = 2'h2;
  localparam logic [1:0] PHASE_FAULT = 2'h3;
  // fault codes
  localparam logic [3:0] FC_NONE = 4'h0;
  localparam logic [3:0] FC_IN_OVP = 4'h1;
  localparam logic [3:0] FC_LOW_SUPPLY = 4'h2;
  localparam logic [3:0] FC_THERMAL = 4'h3;
  localparam logic [3:0] FC_BAT_TEMP = 4'h4;
  localparam logic [3:0] FC_TIMER = 4'h5;
  localparam logic [3:0] FC_BAT_OVP = 4'h6;
  localparam logic [3:0] FC_NO_BAT = 4'h7;
  localparam logic [3:0] FC_SLEEP = 4'h8;
  localparam logic [3:0] FC_WDOG = 4'h9;
  // thermistor zone flags, already compared by the analog front end
  typedef struct packed {
    logic ts_off;
    logic hot;
    logic warm;
    logic cool;
    logic cold;
  } therm_zone_t;
  // analog fault and loop flags
  typedef struct packed {
    logic uvlo;
    logic sleep;
    logic in_ovp;
    logic battery_overvolt;
    logic no_bat;
    logic tj_shutdown;
    logic tj_reg;
    logic input_voltage_limit_loop;
    logic input_current_limit;
  } analog_flags_t;
endpackage

// >>> verilog/tick_div.sv
// divider giving a one-cycle tick every DIV cycles while run is high
module tick_div #(
  parameter int unsigned DIV = 50_000_000
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic run,
  output logic tick
);
  initial begin
    if (DIV < 2) $error("tick_div: DIV must be at least 2");
  end
  logic [31:0] cnt_r;
  // count while running; hold when stopped
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_r <= 32'h0;
      tick <= 1'b0;
    end else if (run) begin
      tick <= (cnt_r == 32'(DIV - 1));
      cnt_r <= (cnt_r == 32'(DIV - 1)) ? 32'h0 : cnt_r + 32'h1;
    end else begin
      tick <= 1'b0;
    end
  end
endmodule // tick_div

// >>> verilog/charge_supervision_timers.sv
// safety timer, host watchdog, thermistor zones, thermal gating and status pin
// Operation
// RL1: safety timer starts with a charge cycle and runs throughout charging.
// RL2: safety expiry before termination suspends charging.
// RL3: safety fault gives one 128 us pulse and updates phase and fault codes.
// RL4: safety fault latched until charge-off, hi-z or supply toggles.
// RL5: duration from select field; new duration restarts an active timer.
// RL6: slow enable halves timer rate in limit loops, warm/cool, reduced charge.
// RL7: 30 s host watchdog starts at first host write.
// RL8: kick bit restarts watchdog and self-clears.
// RL9: host must keep kicking while supply is present.
// RL10: watchdog expiry loads defaults; safety restarts at 2 minutes.
// RL11: gate LDO on with supply; off on uvlo, sleep or thermal shutdown.
// RL12: hot or cold zone suspends charging and timers.
// RL13: cool zone halves charge current.
// RL14: warm zone lowers regulation voltage by 140 mV.
// RL15: thermistor above disable threshold turns off zone handling.
// RL16: junction regulation reduces input current toward zero.
// RL17: thermal shutdown stops converter, suspends timers, pulses, resumes after cooling.
// RL18: indicator low while charging with enable; else high impedance.
// RL19: fault pulses ignore the indicator enable.
// RL20: each listed charge fault gives one pulse then high impedance.
// RL21: default mode lasts until any host write.
// RL22: pulse and timers counted from clock; overlapping pulse requests merge.
module charge_supervision_timers #(
  parameter int unsigned CYC_PER_SEC = chg_sup_pkg::CLK_HZ,
  parameter int unsigned PULSE_CYC = chg_sup_pkg::PULSE_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic supply_present,
  input wire logic charge_request,
  input wire logic charge_terminated,
  input wire logic charge_off,
  input wire logic hiz_mode,
  input wire logic host_write,
  input wire logic watchdog_kick_wr,
  input wire logic [chg_sup_pkg::DUR_W-1:0] safety_duration_sel,
  input wire logic slow_timer_enable,
  input wire logic reduced_charge_sel,
  input wire logic indicator_enable,
  input wire chg_sup_pkg::analog_flags_t flags_in,
  input wire chg_sup_pkg::therm_zone_t zone_in,
  output logic charge_enable_r,
  output logic converter_on_r,
  output logic gate_supply_ldo_r,
  output logic half_current_r,
  output logic vreg_drop_r,
  output logic input_current_reduce_r,
  output logic default_mode_r,
  output logic load_defaults_r,
  output logic watchdog_kick_r,
  output logic [1:0] charge_phase_code_r,
  output logic [3:0] fault_code_r,
  output logic safety_fault_r,
  output logic stat_oe_r,
  output logic stat_out_r,
  output logic int_oe_r,
  output logic int_out_r
);
  initial begin
    if (PULSE_CYC < 1) $error("PULSE_CYC must be at least 1");
    if (CYC_PER_SEC < 4) $error("CYC_PER_SEC must be at least 4");
  end

  // pin-level analog flags are resynchronised
  chg_sup_pkg::analog_flags_t fl_s1, fl;
  chg_sup_pkg::therm_zone_t zn_s1, zn;
  logic sup_s1, sup;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fl_s1 <= '0;
      fl <= '0;
      zn_s1 <= '0;
      zn <= '0;
      sup_s1 <= 1'b0;
      sup <= 1'b0;
    end else begin
      fl_s1 <= flags_in;
      fl <= fl_s1;
      zn_s1 <= zone_in;
      zn <= zn_s1;
      sup_s1 <= supply_present;
      sup <= sup_s1;
    end
  end

  // zone decode, all off when the thermistor input is tied high
  logic z_hot_cold, z_warm, z_cool;
  assign z_hot_cold = !zn.ts_off && (zn.hot || zn.cold); // RL15
  assign z_warm = !zn.ts_off && zn.warm;
  assign z_cool = !zn.ts_off && zn.cool;
  logic tshut;
  assign tshut = fl.tj_shutdown;
  logic sup_ok;
  assign sup_ok = sup && !fl.uvlo && !fl.sleep;

  // timers suspended in thermal shutdown or hot/cold
  logic timers_hold;
  assign timers_hold = tshut || z_hot_cold; // RL12 RL17

  // half-rate condition
  logic slow;
  assign slow = slow_timer_enable && (fl.input_voltage_limit_loop ||
    fl.input_current_limit || fl.tj_reg || z_warm || z_cool ||
    reduced_charge_sel); // RL6

  // one-second time base; half-rate drops every other second tick
  logic sec_tick, half_ph_r, safety_tick;
  tick_div #(.DIV(CYC_PER_SEC)) u_sec (
    .mclk(mclk),
    .rstn(rstn),
    .run(!timers_hold),
    .tick(sec_tick)
  ); // RL22
  always_ff @(posedge mclk) begin
    if (!rstn) half_ph_r <= 1'b0;
    else if (sec_tick) half_ph_r <= !half_ph_r;
  end
  assign safety_tick = sec_tick && (!slow || half_ph_r); // RL6

  // host-controlled versus default mode
  logic wd_expire;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      default_mode_r <= 1'b1;
      load_defaults_r <= 1'b0;
    end else begin
      load_defaults_r <= wd_expire; // RL10
      if (host_write) default_mode_r <= 1'b0; // RL21
      else if (wd_expire) default_mode_r <= 1'b1; // RL10
    end
  end

  // host watchdog, armed by first write, seconds counted on the plain tick
  logic [chg_sup_pkg::SEC_W-1:0] wd_cnt_r;
  logic wd_run_r;
  assign wd_expire = wd_run_r && !host_write && sec_tick &&
    (wd_cnt_r == chg_sup_pkg::SEC_W'(chg_sup_pkg::WDOG_S - 1));
  always_ff @(posedge mclk) begin
    if (!rstn || !sup) begin
      wd_run_r <= 1'b0;
      wd_cnt_r <= '0;
    end else if (host_write) begin
      wd_run_r <= 1'b1; // RL7
      if (watchdog_kick_wr || !wd_run_r) wd_cnt_r <= '0; // RL8
    end else if (wd_expire) begin
      wd_run_r <= 1'b0;
      wd_cnt_r <= '0;
    end else if (wd_run_r && sec_tick) begin
      wd_cnt_r <= wd_cnt_r + 1'b1;
    end
  end

  // kick bit reads back as one for the cycle after being written, then zero
  always_ff @(posedge mclk) begin
    if (!rstn) watchdog_kick_r <= 1'b0;
    else watchdog_kick_r <= host_write && watchdog_kick_wr; // RL8
  end

  // safety duration in seconds
  function automatic logic [chg_sup_pkg::SEC_W-1:0] dur_secs(
      input logic [chg_sup_pkg::DUR_W-1:0] sel, input logic dflt);
    logic [chg_sup_pkg::SEC_W-1:0] s;
    s = '0;
    if (dflt) s = chg_sup_pkg::SEC_W'(chg_sup_pkg::DEFAULT_SAFETY_S);
    else begin
      case (sel)
        2'h0: s = '0; // disabled
        2'h1: s = chg_sup_pkg::SEC_W'(chg_sup_pkg::SAFETY_S_SEL1); // 45 min
        2'h2: s = chg_sup_pkg::SEC_W'(chg_sup_pkg::SAFETY_S_SEL2); // 6 h
        default: s = chg_sup_pkg::SEC_W'(chg_sup_pkg::SAFETY_S_SEL3); // 12 h
      endcase
    end
    return s;
  endfunction

  // safety timer state machine
  typedef enum logic [1:0] {
    SF_IDLE = 2'b00,
    SF_RUN = 2'b01,
    SF_FAULT = 2'b10
  } safety_st_t;
  safety_st_t sf_r;
  logic [chg_sup_pkg::SEC_W-1:0] sf_cnt_r, sf_lim;
  logic [chg_sup_pkg::DUR_W-1:0] dur_q_r;
  logic dflt_q_r, off_q_r, hiz_q_r, sup_q_r, clear_tog, sf_expire;
  assign sf_lim = dur_secs(dur_q_r, dflt_q_r);
  assign clear_tog = (off_q_r != charge_off) || (hiz_q_r != hiz_mode) ||
    (sup_q_r != sup);
  assign sf_expire = (sf_r == SF_RUN) && safety_tick && (sf_lim != '0) &&
    (sf_cnt_r + 1'b1 >= sf_lim) && !charge_terminated;
  logic charging;
  assign charging = charge_request && !charge_off && !hiz_mode && sup_ok &&
    !charge_terminated;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      off_q_r <= 1'b0;
      hiz_q_r <= 1'b0;
      sup_q_r <= 1'b0;
    end else begin
      off_q_r <= charge_off;
      hiz_q_r <= hiz_mode;
      sup_q_r <= sup;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sf_r <= SF_IDLE;
      sf_cnt_r <= '0;
      dur_q_r <= chg_sup_pkg::DUR_SEL_RST;
      dflt_q_r <= 1'b1;
    end else begin
      dur_q_r <= safety_duration_sel;
      dflt_q_r <= default_mode_r;
      case (sf_r)
        SF_IDLE: begin
          sf_cnt_r <= '0;
          if (charging) sf_r <= SF_RUN; // RL1
        end
        SF_RUN: begin
          if (sf_expire) sf_r <= SF_FAULT; // RL2
          else if (!charging) sf_r <= SF_IDLE;
          else if (wd_expire || dur_q_r != safety_duration_sel)
            sf_cnt_r <= '0; // RL5 RL10
          else if (safety_tick) sf_cnt_r <= sf_cnt_r + 1'b1;
        end
        SF_FAULT: begin
          sf_cnt_r <= '0;
          if (clear_tog) sf_r <= SF_IDLE; // RL4
        end
        default: sf_r <= SF_IDLE;
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) safety_fault_r <= 1'b0;
    else safety_fault_r <= (sf_r == SF_FAULT) || sf_expire; // RL4
  end

  // charge path and analog steering
  logic run_ok;
  assign run_ok = charging && (sf_r != SF_FAULT) && !sf_expire && !tshut &&
    !z_hot_cold && !fl.in_ovp && !fl.battery_overvolt && !fl.no_bat;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      charge_enable_r <= 1'b0;
      converter_on_r <= 1'b0;
      gate_supply_ldo_r <= 1'b0;
      half_current_r <= 1'b0;
      vreg_drop_r <= 1'b0;
      input_current_reduce_r <= 1'b0;
    end else begin
      charge_enable_r <= run_ok; // RL2 RL12
      converter_on_r <= sup_ok && !tshut && !hiz_mode; // RL17
      gate_supply_ldo_r <= sup_ok && !tshut; // RL11
      half_current_r <= z_cool; // RL13
      vreg_drop_r <= z_warm; // RL14
      input_current_reduce_r <= fl.tj_reg || tshut; // RL16
    end
  end

  // fault events: rising edges of each charge fault
  logic [7:0] fault_now, fault_q_r, fault_rise;
  assign fault_now = {sf_r == SF_FAULT, fl.sleep, fl.in_ovp, fl.uvlo,
    fl.battery_overvolt, tshut, fl.no_bat, z_hot_cold && charge_request};
  always_ff @(posedge mclk) begin
    if (!rstn) fault_q_r <= '0;
    else fault_q_r <= fault_now;
  end
  assign fault_rise = fault_now & ~fault_q_r;
  logic pulse_req;
  assign pulse_req = (|fault_rise) || wd_expire; // RL20

  // status codes
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fault_code_r <= chg_sup_pkg::FC_NONE;
      charge_phase_code_r <= chg_sup_pkg::PHASE_READY;
    end else begin
      if (fault_rise[7]) fault_code_r <= chg_sup_pkg::FC_TIMER; // RL3
      else if (fault_rise[2]) fault_code_r <= chg_sup_pkg::FC_THERMAL; // RL17
      else if (fault_rise[5]) fault_code_r <= chg_sup_pkg::FC_IN_OVP;
      else if (fault_rise[4]) fault_code_r <= chg_sup_pkg::FC_LOW_SUPPLY;
      else if (fault_rise[6]) fault_code_r <= chg_sup_pkg::FC_SLEEP;
      else if (fault_rise[3]) fault_code_r <= chg_sup_pkg::FC_BAT_OVP;
      else if (fault_rise[1]) fault_code_r <= chg_sup_pkg::FC_NO_BAT;
      else if (fault_rise[0]) fault_code_r <= chg_sup_pkg::FC_BAT_TEMP;
      else if (wd_expire) fault_code_r <= chg_sup_pkg::FC_WDOG;
      else if (clear_tog && !(|fault_now)) fault_code_r <= chg_sup_pkg::FC_NONE;
      if (|fault_now) charge_phase_code_r <= chg_sup_pkg::PHASE_FAULT; // RL3
      else if (run_ok) charge_phase_code_r <= chg_sup_pkg::PHASE_CHARGING;
      else if (charge_terminated) charge_phase_code_r <= chg_sup_pkg::PHASE_DONE;
      else charge_phase_code_r <= chg_sup_pkg::PHASE_READY;
    end
  end

  // fault pulse stretcher; requests during a pulse merge into it
  logic [31:0] pls_cnt_r;
  logic pls_on;
  assign pls_on = pls_cnt_r != 32'h0;
  always_ff @(posedge mclk) begin
    if (!rstn) pls_cnt_r <= 32'h0;
    else if (pulse_req && !pls_on) pls_cnt_r <= 32'(PULSE_CYC); // RL3 RL22
    else if (pls_on) pls_cnt_r <= pls_cnt_r - 32'h1;
  end

  // open-drain status pins: drive low while charging with indicator_enable set, or while pulsing
  logic drive_low;
  assign drive_low = (pulse_req && !pls_on) || (pls_cnt_r > 32'h1) ||
    (run_ok && indicator_enable); // RL18 RL19
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      stat_oe_r <= 1'b0;
      int_oe_r <= 1'b0;
      stat_out_r <= 1'b0;
      int_out_r <= 1'b0;
    end else begin
      stat_oe_r <= drive_low; // RL18
      int_oe_r <= drive_low; // RL19
      stat_out_r <= 1'b0;
      int_out_r <= 1'b0;
    end
  end

  // checks
  sequence s_fault_start;
    $rose(sf_r == SF_FAULT);
  endsequence
  property p_pulse_on_timer_fault;
    @(posedge mclk) disable iff (!rstn) s_fault_start |-> ##[0:2] stat_oe_r;
  endproperty
  a_pulse_on_timer_fault: assert property (p_pulse_on_timer_fault) // RL3
    else $error("no pulse on safety fault");
  property p_fault_stops_charge;
    @(posedge mclk) disable iff (!rstn) (sf_r == SF_FAULT) |=> !charge_enable_r;
  endproperty
  a_fault_stops_charge: assert property (p_fault_stops_charge) // RL2
    else $error("charging during safety fault");
  property p_fault_latched;
    @(posedge mclk) disable iff (!rstn)
      (sf_r == SF_FAULT && !clear_tog) |=> (sf_r == SF_FAULT);
  endproperty
  a_fault_latched: assert property (p_fault_latched) // RL4
    else $error("safety fault cleared without toggle");
  property p_kick_clears;
    @(posedge mclk) disable iff (!rstn) watchdog_kick_r |=> !watchdog_kick_r || $past(host_write);
  endproperty
  a_kick_clears: assert property (p_kick_clears) // RL8
    else $error("kick bit not self-cleared");
  property p_ldo_off_tshut;
    @(posedge mclk) disable iff (!rstn) tshut |=> !gate_supply_ldo_r;
  endproperty
  a_ldo_off_tshut: assert property (p_ldo_off_tshut) // RL11
    else $error("gate ldo on in thermal shutdown");
  property p_hold_timers;
    @(posedge mclk) disable iff (!rstn) timers_hold |-> ##1 !sec_tick;
  endproperty
  a_hold_timers: assert property (p_hold_timers) // RL12
    else $error("timer ticked while suspended");
  property p_ts_off;
    @(posedge mclk) disable iff (!rstn) zn.ts_off |=> !half_current_r && !vreg_drop_r;
  endproperty
  a_ts_off: assert property (p_ts_off) // RL15
    else $error("zone handling while disabled");
  property p_default_exit;
    @(posedge mclk) disable iff (!rstn) host_write |=> !default_mode_r;
  endproperty
  a_default_exit: assert property (p_default_exit) // RL21
    else $error("default mode kept after write");
endmodule // charge_supervision_timers

// >>> bench/host_model.sv
// host processor model issuing register writes and watchdog kicks
module host_model (
  input wire logic mclk,
  output logic host_write,
  output logic watchdog_kick_wr
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle host at time zero
  initial begin
    host_write = 1'b0;
    watchdog_kick_wr = 1'b0;
  end
  // one register write of one cycle, launched at the falling edge
  task automatic wr(input logic kick);
    @(negedge mclk);
    host_write = 1'b1;
    watchdog_kick_wr = kick;
    @(negedge mclk);
    host_write = 1'b0;
    watchdog_kick_wr = ~kick; // stale kick value is not held
  endtask
endmodule // host_model

// >>> bench/tb_top.sv
// self-checking bench for the charge supervision timers
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CPS = 10;
  localparam int PCYC = 6;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic supply_present = 1'b0, charge_request = 1'b0, charge_terminated = 1'b0;
  logic charge_off = 1'b0, hiz_mode = 1'b0, slow_timer_enable = 1'b0;
  logic reduced_charge_sel = 1'b0, indicator_enable = 1'b0;
  logic [chg_sup_pkg::DUR_W-1:0] safety_duration_sel = 2'h1;
  chg_sup_pkg::analog_flags_t flags_in = '0;
  chg_sup_pkg::therm_zone_t zone_in = '0;
  logic host_write, watchdog_kick_wr;
  logic charge_enable_r, converter_on_r, gate_supply_ldo_r, half_current_r, vreg_drop_r;
  logic input_current_reduce_r, default_mode_r, load_defaults_r, watchdog_kick_r;
  logic [1:0] charge_phase_code_r;
  logic [3:0] fault_code_r;
  logic safety_fault_r, stat_oe_r, stat_out_r, int_oe_r, int_out_r;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  // 50 MHz clock
  always #10 mclk = ~mclk;
  host_model host_model_i (.mclk(mclk), .host_write(host_write),
    .watchdog_kick_wr(watchdog_kick_wr));
  charge_supervision_timers #(.CYC_PER_SEC(CPS), .PULSE_CYC(PCYC)) charge_supervision_timers_i (
    .mclk(mclk), .rstn(rstn), .supply_present(supply_present),
    .charge_request(charge_request), .charge_terminated(charge_terminated),
    .charge_off(charge_off), .hiz_mode(hiz_mode), .host_write(host_write),
    .watchdog_kick_wr(watchdog_kick_wr), .safety_duration_sel(safety_duration_sel),
    .slow_timer_enable(slow_timer_enable), .reduced_charge_sel(reduced_charge_sel),
    .indicator_enable(indicator_enable), .flags_in(flags_in), .zone_in(zone_in),
    .charge_enable_r(charge_enable_r), .converter_on_r(converter_on_r),
    .gate_supply_ldo_r(gate_supply_ldo_r), .half_current_r(half_current_r),
    .vreg_drop_r(vreg_drop_r), .input_current_reduce_r(input_current_reduce_r),
    .default_mode_r(default_mode_r), .load_defaults_r(load_defaults_r),
    .watchdog_kick_r(watchdog_kick_r), .charge_phase_code_r(charge_phase_code_r),
    .fault_code_r(fault_code_r), .safety_fault_r(safety_fault_r), .stat_oe_r(stat_oe_r),
    .stat_out_r(stat_out_r), .int_oe_r(int_oe_r), .int_out_r(int_out_r));
  // verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
  task automatic settle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // wait for a fault pulse, measure its width on int_oe_r and check stat_oe_r is set throughout it
  task automatic pulse_chk(input int lim);
    int n, w;
    n = 0;
    w = 0;
    while (int_oe_r !== 1'b1 && n < lim) begin
      @(negedge mclk);
      n++;
    end
    while (int_oe_r === 1'b1 && w < 100) begin
      `CHK(stat_oe_r, 1'b1)
      @(negedge mclk);
      w++;
    end
    `CHK(w, PCYC)
    `CHK(int_out_r, 1'b0)
    `CHK(stat_out_r, 1'b0)
  endtask
  // reset values
  task automatic t_reset;
    `CHK(default_mode_r, 1'b1)
    `CHK(int_oe_r, 1'b0)
    `CHK(safety_fault_r, 1'b0)
    $display("test reset done");
  endtask
  // safety expiry at the default duration, normal or half rate
  task automatic t_safety(input logic slow);
    slow_timer_enable = slow;
    reduced_charge_sel = slow;
    charge_off = 1'b1;
    settle(3);
    charge_off = 1'b0;
    settle(8);
    `CHK(charge_enable_r, 1'b1)
    `CHK(stat_oe_r, 1'b0)
    `CHK(charge_phase_code_r, chg_sup_pkg::PHASE_CHARGING)
    settle(600);
    `CHK(safety_fault_r, 1'b0)
    // new duration select while running restarts the count
    safety_duration_sel = safety_duration_sel + 2'h1;
    settle(slow ? 2000 : 1000);
    `CHK(safety_fault_r, 1'b0)
    pulse_chk(slow ? 600 : 400);
    `CHK(safety_fault_r, 1'b1)
    `CHK(charge_enable_r, 1'b0)
    `CHK(fault_code_r, chg_sup_pkg::FC_TIMER)
    `CHK(charge_phase_code_r, chg_sup_pkg::PHASE_FAULT)
    settle(50);
    `CHK(safety_fault_r, 1'b1)
    hiz_mode = 1'b1;
    settle(3);
    hiz_mode = 1'b0;
    settle(8);
    `CHK(safety_fault_r, 1'b0)
    $display("test safety done");
  endtask
  // thermistor zones, thermal loops and indicator level
  task automatic t_analog;
    slow_timer_enable = 1'b0;
    reduced_charge_sel = 1'b0;
    indicator_enable = 1'b1;
    settle(6);
    `CHK(stat_oe_r, 1'b1)
    charge_terminated = 1'b1;
    settle(6);
    `CHK(stat_oe_r, 1'b0)
    `CHK(charge_phase_code_r, chg_sup_pkg::PHASE_DONE)
    charge_terminated = 1'b0;
    indicator_enable = 1'b0;
    zone_in.cool = 1'b1;
    settle(6);
    `CHK(half_current_r, 1'b1)
    zone_in.ts_off = 1'b1;
    settle(6);
    `CHK(half_current_r, 1'b0)
    zone_in = '0;
    zone_in.warm = 1'b1;
    settle(6);
    `CHK(vreg_drop_r, 1'b1)
    zone_in = '0;
    zone_in.hot = 1'b1;
    settle(6);
    `CHK(charge_enable_r, 1'b0)
    zone_in = '0;
    flags_in.tj_reg = 1'b1;
    settle(20);
    `CHK(charge_enable_r, 1'b1)
    `CHK(input_current_reduce_r, 1'b1)
    flags_in = '0;
    flags_in.tj_shutdown = 1'b1;
    pulse_chk(10);
    `CHK(converter_on_r, 1'b0)
    `CHK(gate_supply_ldo_r, 1'b0)
    `CHK(fault_code_r, chg_sup_pkg::FC_THERMAL)
    flags_in = '0;
    settle(6);
    `CHK(gate_supply_ldo_r, 1'b1)
    flags_in.sleep = 1'b1;
    settle(6);
    `CHK(gate_supply_ldo_r, 1'b0)
    flags_in = '0;
    settle(20);
    // remaining charge faults, one pulse each
    flags_in.in_ovp = 1'b1;
    pulse_chk(10);
    `CHK(fault_code_r, chg_sup_pkg::FC_IN_OVP)
    flags_in = '0;
    settle(10);
    flags_in.battery_overvolt = 1'b1;
    pulse_chk(10);
    `CHK(fault_code_r, chg_sup_pkg::FC_BAT_OVP)
    flags_in = '0;
    settle(10);
    flags_in.no_bat = 1'b1;
    pulse_chk(10);
    `CHK(fault_code_r, chg_sup_pkg::FC_NO_BAT)
    flags_in = '0;
    settle(10);
    flags_in.uvlo = 1'b1;
    pulse_chk(10);
    `CHK(fault_code_r, chg_sup_pkg::FC_LOW_SUPPLY)
    `CHK(gate_supply_ldo_r, 1'b0)
    flags_in = '0;
    settle(20);
    $display("test analog done");
  endtask
  // host watchdog start, kick, self-clear and expiry
  task automatic t_watchdog;
    int n, k;
    k = 0;
    host_model_i.wr(1'b0);
    settle(2);
    `CHK(default_mode_r, 1'b0)
    settle(200);
    host_model_i.wr(1'b1);
    for (n = 0; n < 4; n++) begin
      k += (watchdog_kick_r === 1'b1) ? 1 : 0;
      @(negedge mclk);
    end
    `CHK(k, 1)
    for (n = 0; n < 250; n++) begin
      if (load_defaults_r !== 1'b0) k = 9;
      @(negedge mclk);
    end
    `CHK(k, 1)
    for (n = 0; n < 100 && load_defaults_r !== 1'b1; n++) @(negedge mclk);
    `CHK(load_defaults_r, 1'b1)
    settle(3);
    `CHK(default_mode_r, 1'b1)
    `CHK(fault_code_r, chg_sup_pkg::FC_WDOG)
    $display("test watchdog done");
  endtask
  // main sequence
  initial begin
    settle(2);
    rstn = 1'b1;
    supply_present = 1'b1;
    charge_request = 1'b1;
    t_reset();
    t_safety(1'b0);
    t_safety(1'b1);
    t_analog();
    t_watchdog();
    stop_test();
  end
endmodule // tb_top
